// ==== pkg/bidir_port_regs.vh ====
`ifndef BIDIR_PORT_REGS_VH
`define BIDIR_PORT_REGS_VH

// register offsets (byte addresses on the plain register port)
`define OFF_FIRST_PINS     8'h05
`define OFF_SECOND_PINS    8'h06
`define OFF_COMPARATOR     8'h1F
`define OFF_PULLUP_CFG     8'h81
`define OFF_FIRST_DIR      8'h85
`define OFF_SECOND_DIR     8'h86
`define OFF_REFERENCE      8'h9F
`define OFF_INT_CONTROL    8'h0B
`define OFF_INT_MASK       8'h8B

// reset values
`define RST_PULLUP_CFG     8'hFF
`define RST_FIRST_DIR      5'h1F
`define RST_SECOND_DIR     8'hFF
`define RST_COMPARATOR     8'h00
`define RST_REFERENCE      8'h00
`define RST_FIRST_LATCH    5'h00
`define RST_INT_MASK       8'h00

// field positions and masks
`define PULLUP_EN_N_BIT    7
`define CHANGE_FLAG_BIT    0
`define FIRST_PORT_MASK    8'h1F
`define COMPARATOR_MASK    8'hCF
`define REFERENCE_MASK     8'hEF
`define CHANGE_PIN_MASK    8'hF0
`define CMP_MODE_LSB       0
`define CMP_MODE_OFF       3'h7
`define CMP_ANALOG_ALL     4'hF
`define CMP_ANALOG_LOW2    4'h3
`define CMP_MODE_ALL_IN    3'h0
`define CMP_MODE_TWO_IN    3'h6

`endif

// ==== hw/bidir_port_with_change_irq.v ====
`timescale 1ns/10ps
`default_nettype none
`include "bidir_port_regs.vh"

module bidir_port_with_change_irq (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWrStrobe,
	input  wire       regRdStrobe,
	output reg  [7:0] regRdData,
	input  wire [7:0] secondPortIn,
	output reg  [7:0] secondPortOut,
	output reg  [7:0] secondPortOe,
	output reg  [7:0] secondPortPullup,
	input  wire [4:0] firstPortIn,
	output reg  [4:0] firstPortOut,
	output reg  [4:0] firstPortOe,
	output reg        irqOut,
	output reg        wakeOut
);

	// change-flag state machine: idle or a mismatch still standing
	localparam [0:0] ST_MATCH    = 1'b0;
	localparam [0:0] ST_MISMATCH = 1'b1;

	reg  [7:0] secondLatch_reg;
	reg  [7:0] secondDir_reg;
	reg  [7:0] pullupCfg_reg;
	reg  [4:0] firstLatch_reg;
	reg  [4:0] firstDir_reg;
	reg  [7:0] comparator_reg;
	reg  [7:0] reference_reg;
	reg  [7:0] changeRef_reg;
	reg  [7:0] intStatus_reg;
	reg  [7:0] intMask_reg;
	reg        changeState_reg;

	reg  [7:0] rdNext;
	reg        changeState_next;
	wire [7:0] changeMask;
	wire [7:0] mismatch;
	wire       changeSeen;
	wire       secondRead;
	wire       secondWrite;
	wire [4:0] analogPins;
	wire [7:0] firstPinView;
	wire [7:0] intStatus_next;

	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// pins that the comparator mode claims as analog inputs
	function [4:0] analogOf;
		input [2:0] mode;
		begin
			case (mode)
				`CMP_MODE_ALL_IN: analogOf = {1'b0, `CMP_ANALOG_ALL};
				`CMP_MODE_OFF:    analogOf = 5'h00;
				`CMP_MODE_TWO_IN: analogOf = {3'b000, 2'b11};
				default:          analogOf = {1'b0, `CMP_ANALOG_ALL};
			endcase
		end
	endfunction

	assign secondRead  = regRdStrobe & hit(regAddr, `OFF_SECOND_PINS);
	assign secondWrite = regWrStrobe & hit(regAddr, `OFF_SECOND_PINS);
	assign analogPins  = analogOf(comparator_reg[`CMP_MODE_LSB +: 3]);
	assign firstPinView = {3'b000, firstPortIn & ~analogPins};

	// only input pins of the upper nibble take part
	assign changeMask = `CHANGE_PIN_MASK & secondDir_reg;
	assign mismatch   = (secondPortIn ^ changeRef_reg) & changeMask;
	// a read refreshes the reference this cycle, so a change landing on
	// the read cycle is absorbed and may not flag
	assign changeSeen = (|mismatch) & ~secondRead;

	always @* begin
		changeState_next = changeState_reg;
		case (changeState_reg)
			ST_MATCH:    if (changeSeen) changeState_next = ST_MISMATCH;
			ST_MISMATCH: if (!changeSeen) changeState_next = ST_MATCH;
			default:     changeState_next = ST_MATCH;
		endcase
	end

	// write-one-to-clear; a standing mismatch sets again and wins
	assign intStatus_next = ((regWrStrobe && hit(regAddr, `OFF_INT_CONTROL))
		? (intStatus_reg & ~regWrData) : intStatus_reg)
		| {7'h00, changeSeen};

	always @* begin
		rdNext = 8'h00;
		case (regAddr)
			`OFF_FIRST_PINS:  rdNext = firstPinView;
			`OFF_SECOND_PINS: rdNext = secondPortIn;
			`OFF_COMPARATOR:  rdNext = comparator_reg & `COMPARATOR_MASK;
			`OFF_PULLUP_CFG:  rdNext = pullupCfg_reg;
			`OFF_FIRST_DIR:   rdNext = {3'b000, firstDir_reg};
			`OFF_SECOND_DIR:  rdNext = secondDir_reg;
			`OFF_REFERENCE:   rdNext = reference_reg & `REFERENCE_MASK;
			`OFF_INT_CONTROL: rdNext = intStatus_reg;
			`OFF_INT_MASK:    rdNext = intMask_reg;
			default:          rdNext = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secondLatch_reg <= 8'h00;
			secondDir_reg   <= `RST_SECOND_DIR;
			pullupCfg_reg   <= `RST_PULLUP_CFG;
			firstLatch_reg  <= `RST_FIRST_LATCH;
			firstDir_reg    <= `RST_FIRST_DIR;
			comparator_reg  <= `RST_COMPARATOR;
			reference_reg   <= `RST_REFERENCE;
			changeRef_reg   <= 8'h00;
			intStatus_reg   <= 8'h00;
			intMask_reg     <= `RST_INT_MASK;
			changeState_reg <= ST_MATCH;
			regRdData       <= 8'h00;
		end else begin
			changeState_reg <= changeState_next;
			intStatus_reg   <= intStatus_next & 8'h01;
			if (regRdStrobe) begin
				regRdData <= rdNext;
			end else begin
				regRdData <= 8'h00;
			end
			// any read or write of port B ends the mismatch
			if (secondRead || secondWrite) begin
				changeRef_reg <= secondPortIn;
			end
			if (regWrStrobe) begin
				case (regAddr)
					// the write data is the CPU's modified copy of
					// the sampled pins; it lands at cycle end
					`OFF_SECOND_PINS: secondLatch_reg <= regWrData;
					`OFF_FIRST_PINS:  firstLatch_reg  <= regWrData[4:0];
					`OFF_SECOND_DIR:  secondDir_reg   <= regWrData;
					`OFF_FIRST_DIR:   firstDir_reg    <= regWrData[4:0];
					`OFF_PULLUP_CFG:  pullupCfg_reg   <= regWrData;
					`OFF_COMPARATOR:  comparator_reg  <= regWrData & `COMPARATOR_MASK;
					`OFF_REFERENCE:   reference_reg   <= regWrData & `REFERENCE_MASK;
					`OFF_INT_MASK:    intMask_reg     <= regWrData & 8'h01;
					default:          ;
				endcase
			end
		end
	end

	// pin drivers registered so every output leaves a flip-flop
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secondPortOut    <= 8'h00;
			secondPortOe     <= 8'h00;
			secondPortPullup <= 8'h00;
			firstPortOut     <= 5'h00;
			firstPortOe      <= 5'h00;
			irqOut           <= 1'b0;
			wakeOut          <= 1'b0;
		end else begin
			secondPortOut    <= secondLatch_reg;
			secondPortOe     <= ~secondDir_reg;
			secondPortPullup <= {8{~pullupCfg_reg[`PULLUP_EN_N_BIT]}}
				& secondDir_reg;
			firstPortOut     <= firstLatch_reg;
			firstPortOe      <= ~firstDir_reg;
			irqOut           <= |(intStatus_reg & intMask_reg);
			// wake does not depend on the mask: sleep exit on any change of an upper-nibble input pin
			wakeOut          <= intStatus_reg[`CHANGE_FLAG_BIT];
		end
	end

endmodule // bidir_port_with_change_irq
`default_nettype wire

// ==== verification/bidir_port_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module bidir_port_monitor (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrStrobe,
	input wire logic       regRdStrobe,
	input wire logic [7:0] regRdData,
	input wire logic [7:0] secondPortIn,
	input wire logic [7:0] secondPortOut,
	input wire logic [7:0] secondPortOe,
	input wire logic [7:0] secondPortPullup,
	input wire logic       irqOut,
	input wire logic       wakeOut
);
	wire wrPin = regWrStrobe && regAddr == 8'h06;
	wire wrDir = regWrStrobe && regAddr == 8'h86;
	wire wrOpt = regWrStrobe && regAddr == 8'h81;
	wire clrFlag = regWrStrobe && regAddr == 8'h0B && regWrData[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_latch_drives_pin: assert property (
		wrPin |-> ##2 secondPortOut == $past(regWrData, 2)) else $error("latch");
	a_oe_from_dir: assert property (
		wrDir |-> ##2 secondPortOe == ~$past(regWrData, 2)) else $error("dir");
	a_no_pullup_out: assert property (
		(secondPortPullup & secondPortOe) == 8'h00) else $error("pullup on out");
	a_pullup_global: assert property (
		wrOpt && !regWrData[7] ##1 !wrOpt |=> secondPortPullup == ~secondPortOe)
		else $error("pullup enable");
	a_pin_readback: assert property (
		regRdStrobe && regAddr == 8'h06 |=> regRdData == $past(secondPortIn))
		else $error("pin read");
	a_unused_zero: assert property (
		regRdStrobe && regAddr == 8'h05 |=> regRdData[7:5] == 3'h0)
		else $error("unused bits");
	a_unmapped_read: assert property (
		regRdStrobe && regAddr == 8'h10 |=> regRdData == 8'h00)
		else $error("unmapped");
	a_flag_sticky: assert property (
		wakeOut && !clrFlag && !$past(clrFlag) |=> wakeOut) else $error("flag lost");
	c_wake: cover property (wakeOut);
	c_irq: cover property (irqOut);
	c_clear: cover property (clrFlag ##1 wakeOut);
endmodule // bidir_port_monitor
bind bidir_port_with_change_irq bidir_port_monitor bidir_port_monitor_i (.*);
`default_nettype wire

// ==== verification/pin_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
	input  wire logic [7:0] secondPortOut,
	input  wire logic [7:0] secondPortOe,
	input  wire logic [7:0] secondPortPullup,
	input  wire logic [7:0] extDrive,
	input  wire logic [7:0] extEn,
	output wire logic [7:0] secondPortIn
);
	// a floating pin with no pull-up shows the inverse of the latch,
	// never a stale level
	assign secondPortIn = (secondPortOe & secondPortOut)
		| (~secondPortOe & extEn & extDrive)
		| (~secondPortOe & ~extEn & (secondPortPullup | ~secondPortOut));
endmodule // pin_partner
`default_nettype wire

// ==== verification/bidir_port_with_change_irq_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module bidir_port_with_change_irq_bench;
	logic clk = 0, rst_n = 0, regWrStrobe = 0, regRdStrobe = 0, irqOut, wakeOut;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, secondPortIn;
	logic [7:0] secondPortOut, secondPortOe, secondPortPullup;
	logic [7:0] extDrive = 8'hC0, extEn = 8'hF0;
	logic [4:0] firstPortIn = 5'h15, firstPortOut, firstPortOe;
	int checks = 0, mismatches = 0;
	bidir_port_with_change_irq bidir_port_with_change_irq_i (.*);
	pin_partner pin_partner_i (.*);
	always #20 clk = ~clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a; regWrData <= d; regWrStrobe <= 1'b1;
		@(posedge clk);
		regWrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a; regRdStrobe <= 1'b1;
		@(posedge clk);
		regRdStrobe <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h81, 8'hFF);
		rd(8'h86, 8'hFF);
		rd(8'h85, 8'h1F);
		rd(8'h9F, 8'h00);
		rd(8'h10, 8'h00);
		rd(8'h05, 8'h10);
		wr(8'h1F, 8'h07);
		rd(8'h05, 8'h15);
		chk(secondPortPullup, 8'h00);
		$display("end test reset");
		wr(8'h86, 8'hF0);
		wr(8'h06, 8'hA5);
		tick(1);
		chk(secondPortOe, 8'h0F);
		rd(8'h06, 8'hC5);
		$display("end test direction");
		extEn <= 8'h00;
		wr(8'h81, 8'h7F);
		tick(1);
		chk(secondPortPullup, 8'hF0);
		rd(8'h06, 8'hF5);
		$display("end test pullup");
		extEn <= 8'hFF;
		wr(8'h86, 8'hFF);
		wr(8'h8B, 8'h01);
		rd(8'h06, 8'hC0);
		// the pin swap above already flagged; clear so the next change counts
		wr(8'h0B, 8'h01);
		tick(3);
		chk(wakeOut, 1'b0);
		extDrive <= 8'hD0;
		tick(4);
		chk(wakeOut, 1'b1);
		chk(irqOut, 1'b1);
		rd(8'h0B, 8'h01);
		wr(8'h0B, 8'h01);
		tick(3);
		chk(wakeOut, 1'b1);
		rd(8'h06, 8'hD0);
		wr(8'h0B, 8'h01);
		tick(3);
		chk(irqOut, 1'b0);
		wr(8'h8B, 8'h00);
		extDrive <= 8'hF0;
		tick(4);
		chk({irqOut, wakeOut}, 8'h01);
		rd(8'h06, 8'hF0);
		wr(8'h0B, 8'h01);
		wr(8'h86, 8'h0F);
		extDrive <= 8'h05;
		tick(4);
		chk(wakeOut, 1'b0);
		$display("end test change");
		print_verdict;
	end
endmodule // bidir_port_with_change_irq_bench
`default_nettype wire
